// *** design/iibu_flag_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
// combinational increment / invert datapath with its flag results
module iibu_flag_alu
(
	iibu_flag_if.alu fl
);
	logic [iibu_pkg::DATA_W-1:0] sum;
	logic [iibu_pkg::DATA_W-1:0] res;
	logic msb_in;
	logic msb_out;
	logic zero_out;
	logic carry_out;
	logic [iibu_pkg::DATA_W:0] wide;

	// -------------------------------------------------------------
	// arithmetic; word carry comes from the adder's top bit, byte carry from operand[7] and sum[7]
	// -------------------------------------------------------------
	always_comb
	begin
		wide = '0;
		sum = '0;
		res = fl.operand;
		carry_out = 1'b0;
		unique case (fl.op)
			iibu_pkg::IIBU_OP_INC:
			begin
				wide = {1'b0, fl.operand} + {1'b0, iibu_pkg::STEP_ONE};
			end
			iibu_pkg::IIBU_OP_INC2:
			begin
				wide = {1'b0, fl.operand} + {1'b0, iibu_pkg::STEP_TWO};
			end
			default:
			begin
				wide = '0;
			end
		endcase
		sum = wide[iibu_pkg::DATA_W-1:0];
		if (fl.op == iibu_pkg::IIBU_OP_NOT)
			res = fl.operand ^ iibu_pkg::ALL_ONES;
		else if (fl.op == iibu_pkg::IIBU_OP_INC || fl.op == iibu_pkg::IIBU_OP_INC2)
			res = sum;
		if (fl.byte_mode)
		begin
			res = {8'h00, res[7:0]};
			msb_in = fl.operand[7];
			msb_out = res[7];
			carry_out = fl.operand[7] & ~sum[7];
		end
		else
		begin
			msb_in = fl.operand[15];
			msb_out = res[15];
			carry_out = wide[iibu_pkg::DATA_W];
		end
		zero_out = (res == iibu_pkg::DATA_RESET);
	end

	assign fl.result = res;
	assign fl.flag_n = msb_out;
	// zero after +1/+2 only from FFFF/FFFE (or FF/FE); after invert from all ones
	assign fl.flag_z = zero_out;
	// carry out of the top bit marks the wrap of the last one or two values
	assign fl.flag_c = (fl.op == iibu_pkg::IIBU_OP_NOT) ? ~zero_out : carry_out;
	// positive operand turning negative only happens at 7FFF/7FFE (7F/7E)
	assign fl.flag_v = (fl.op == iibu_pkg::IIBU_OP_NOT) ? msb_in
		: (~msb_in & msb_out);
endmodule // iibu_flag_alu
`default_nettype wire

// *** design/iibu_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
// executes increment, invert and relative-jump operations on registered state
module iibu_unit
#(
	parameter int OFFSET_W = iibu_pkg::OFS_W
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic exec,
	input wire iibu_pkg::iibu_op_t op,
	input wire logic byte_mode,
	input wire logic [iibu_pkg::DATA_W-1:0] operand,
	input wire logic [OFFSET_W-1:0] jump_offset,
	input wire logic load_status,
	input wire logic [iibu_pkg::SR_W-1:0] status_in,
	input wire logic load_pc,
	input wire logic [iibu_pkg::PC_W-1:0] pc_in,
	output logic [iibu_pkg::DATA_W-1:0] result,
	output logic result_valid,
	output logic [iibu_pkg::PC_W-1:0] program_counter,
	output logic branch_taken,
	output logic [iibu_pkg::SR_W-1:0] status
);
	typedef struct packed {
		logic [iibu_pkg::DATA_W-1:0] result;
		logic result_valid;
		logic [iibu_pkg::PC_W-1:0] pc;
		logic taken;
		logic [iibu_pkg::SR_W-1:0] sr;
	} iibu_state_t;

	iibu_state_t st;
	iibu_state_t next_st;
	iibu_flag_if fl ();

	// the jump adder is laid out for the documented offset width only
	if (OFFSET_W != iibu_pkg::OFS_W)
	begin : g_bad_offset_w
		$error("iibu_unit: offset width must be 10");
	end

	// -------------------------------------------------------------
	// flag datapath
	// -------------------------------------------------------------
	assign fl.operand = operand;
	assign fl.byte_mode = byte_mode;
	assign fl.op = op;

	iibu_flag_alu u_alu
	(
		.fl(fl)
	);

	// doubled, sign-extended word offset, wrapped across the whole space
	function automatic logic [iibu_pkg::PC_W-1:0] jump_target(
		input logic [iibu_pkg::PC_W-1:0] pc,
		input logic [OFFSET_W-1:0] ofs);
		logic [iibu_pkg::PC_W-1:0] ext;
		ext = {{(iibu_pkg::PC_W-OFFSET_W-1){ofs[OFFSET_W-1]}}, ofs, 1'b0};
		return pc + ext;
	endfunction

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb
	begin
		logic cond;
		cond = 1'b0;
		next_st = st;
		next_st.result_valid = 1'b0;
		next_st.taken = 1'b0;
		if (load_status)
			next_st.sr = status_in;
		if (load_pc)
			next_st.pc = pc_in;
		if (exec)
		begin
			unique case (op)
				iibu_pkg::IIBU_OP_INC, iibu_pkg::IIBU_OP_INC2, iibu_pkg::IIBU_OP_NOT:
				begin
					next_st.result = fl.result;
					next_st.result_valid = 1'b1;
					// mode bits are left as they stand
					next_st.sr[iibu_pkg::SR_N] = fl.flag_n;
					next_st.sr[iibu_pkg::SR_Z] = fl.flag_z;
					next_st.sr[iibu_pkg::SR_C] = fl.flag_c;
					next_st.sr[iibu_pkg::SR_V] = fl.flag_v;
				end
				iibu_pkg::IIBU_OP_CLRV:
				begin
					// lets a later jump_signed_ge act as jump_if_positive
					next_st.sr[iibu_pkg::SR_V] = 1'b0;
				end
				iibu_pkg::IIBU_OP_NONE:
				begin
					cond = 1'b0;
				end
				default:
				begin
					unique case (op)
						iibu_pkg::IIBU_OP_BR_C:
							cond = st.sr[iibu_pkg::SR_C];
						iibu_pkg::IIBU_OP_BR_Z:
							cond = st.sr[iibu_pkg::SR_Z];
						iibu_pkg::IIBU_OP_BR_GE:
							cond = ~(st.sr[iibu_pkg::SR_N] ^ st.sr[iibu_pkg::SR_V]);
						iibu_pkg::IIBU_OP_BR_LT:
							cond = st.sr[iibu_pkg::SR_N] ^ st.sr[iibu_pkg::SR_V];
						default:
							cond = 1'b1;
					endcase
					// status register is not touched on any jump
					next_st.sr = st.sr;
					if (cond)
						next_st.pc = jump_target(st.pc, jump_offset);
					next_st.taken = cond;
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st.result <= iibu_pkg::DATA_RESET;
			st.result_valid <= 1'b0;
			st.pc <= iibu_pkg::PC_RESET;
			st.taken <= 1'b0;
			st.sr <= iibu_pkg::SR_RESET;
		end
		else
			st <= next_st;
	end

	assign result = st.result;
	assign result_valid = st.result_valid;
	assign program_counter = st.pc;
	assign branch_taken = st.taken;
	assign status = st.sr;
endmodule // iibu_unit
`default_nettype wire

// *** pkg/iibu_flag_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// carries operands and flag results between the unit and its flag stage
interface iibu_flag_if;
	logic [iibu_pkg::DATA_W-1:0] operand;
	logic byte_mode;
	iibu_pkg::iibu_op_t op;
	logic [iibu_pkg::DATA_W-1:0] result;
	logic flag_n;
	logic flag_z;
	logic flag_c;
	logic flag_v;
	modport core (output operand, output byte_mode, output op,
		input result, input flag_n, input flag_z, input flag_c, input flag_v);
	modport alu (input operand, input byte_mode, input op,
		output result, output flag_n, output flag_z, output flag_c, output flag_v);
endinterface
`default_nettype wire

// *** pkg/iibu_pkg.sv ***
// Behaviour
// - increment sets overflow only from 07FFFh/07Fh
// - double increment adds two, negative follows sign
// - double increment zero from 0FFFEh/0FEh
// - double increment carry from top two values
// - double increment overflow from 07FFE-7FFF/07E-07F
// - invert is one's complement of destination
// - invert zero when operand was all ones
// - invert carry is inverse of zero
// - invert overflow when operand was negative
// - mode bits never changed by these operations
// - jump adds doubled sign-extended offset to counter
// - jump reach is -512..+511 words, full range
// - jump_if_carry branches when carry set
// - jump_if_zero branches when zero set
// - jump_signed_ge branches when negative equals overflow
// - jump_signed_less branches when they differ
// - jump_always branches with no test
// - jumps leave status flags unchanged
// - logic, shift, extend, test ops clear overflow
package iibu_pkg;
	localparam int DATA_W = 16;
	localparam int PC_W = 20;
	localparam int OFS_W = 10;
	// -------------------------------------------------------------
	// operation codes
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		IIBU_OP_NONE,
		IIBU_OP_INC,
		IIBU_OP_INC2,
		IIBU_OP_NOT,
		IIBU_OP_BR_C,
		IIBU_OP_BR_Z,
		IIBU_OP_BR_GE,
		IIBU_OP_BR_LT,
		IIBU_OP_BR_ANY,
		IIBU_OP_CLRV
	} iibu_op_t;
	// -------------------------------------------------------------
	// status bit positions
	// -------------------------------------------------------------
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_IRQ_EN = 3;
	localparam int SR_CORE_OFF = 4;
	localparam int SR_OSC_OFF = 5;
	localparam int SR_V = 8;
	localparam int SR_W = 9;
	localparam logic [SR_W-1:0] SR_RESET = 9'h000;
	localparam logic [PC_W-1:0] PC_RESET = 20'h00000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] STEP_ONE = 16'h0001;
	localparam logic [DATA_W-1:0] STEP_TWO = 16'h0002;
	localparam logic [DATA_W-1:0] ALL_ONES = 16'hFFFF;
endpackage

// *** verification/iibu_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------
// flag and jump checks
// ---------------------------------
module iibu_props
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic exec,
	input wire iibu_pkg::iibu_op_t op,
	input wire logic byte_mode,
	input wire logic [15:0] operand,
	input wire logic [9:0] jump_offset,
	input wire logic load_status,
	input wire logic [15:0] result,
	input wire logic [19:0] program_counter,
	input wire logic branch_taken,
	input wire logic [8:0] status
);
	// word-form qualifier and status aliases, so $past sees plain signals
	wire logic wx = exec && !byte_mode;
	wire logic cf = status[0];
	wire logic nv = status[2] ^ status[8];
	wire logic [2:0] mode = status[5:3];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_inc_ovf: assert property (wx && op == iibu_pkg::IIBU_OP_INC |=>
		status[8] == ($past(operand) == 16'h7FFF)) else $error("inc overflow");
	a_double_increment_carry: assert property (wx && op == iibu_pkg::IIBU_OP_INC2 |=>
		status[0] == ($past(operand) >= 16'hFFFE)) else $error("double_increment carry");
	a_double_increment_ovf: assert property (wx && op == iibu_pkg::IIBU_OP_INC2 |=>
		status[8] == ($past(operand) inside {16'h7FFE, 16'h7FFF})) else $error("double_increment ovf");
	a_inv_flags: assert property (wx && op == iibu_pkg::IIBU_OP_NOT |=>
		result == ~$past(operand) && status[0] == (result != 16'h0000)
		&& status[8] == ($past(operand) >= 16'h8000)) else $error("inv flags");
	a_jump_keep: assert property (exec && op >= iibu_pkg::IIBU_OP_BR_C
		&& op <= iibu_pkg::IIBU_OP_BR_ANY |=> $stable(status)) else $error("jump flags");
	a_jmp_target: assert property (exec && op == iibu_pkg::IIBU_OP_BR_ANY |=>
		branch_taken && program_counter == 20'($past(program_counter)
		+ 20'($signed($past(jump_offset))) * 20'h2)) else $error("jump target");
	a_jc_cond: assert property (exec && op == iibu_pkg::IIBU_OP_BR_C |=>
		branch_taken == $past(cf)) else $error("carry jump");
	a_jge_cond: assert property (exec && op == iibu_pkg::IIBU_OP_BR_GE |=>
		branch_taken == !$past(nv)) else $error("signed jump");
	a_mode_keep: assert property (exec && !load_status |=>
		$stable(mode)) else $error("mode bits");
endmodule // iibu_props
bind iibu_unit iibu_props iibu_props_inst (.*);
`default_nettype wire

// *** verification/tb_iibu_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------
// random run against an integer model
// ---------------------------------
module tb_iibu_unit;
	logic clk_sys = 0, rst = 1, exec = 0, byte_mode = 0, load_status = 0, load_pc = 0;
	iibu_pkg::iibu_op_t op = iibu_pkg::IIBU_OP_NONE;
	logic [15:0] operand = 16'h0000, result;
	logic [9:0] jump_offset = 10'h000;
	logic [8:0] status_in = 9'h000, status;
	logic [19:0] pc_in = 20'h00000, program_counter;
	logic result_valid, branch_taken;
	int miscompares = 0, num_checks = 0, cyc = 0, a, r, c, v, w, s, p;
	int e_res = 0, e_pc = 0, e_st = 0, e_rv = 0, e_bt = 0;
	logic [31:0] x = 32'h116B;
	logic [15:0] edge_val [8] = '{16'h7FFF, 16'h7FFE, 16'hFFFE, 16'hFFFF,
		16'h007F, 16'h007E, 16'h00FE, 16'h00FF};
	iibu_unit iibu_unit_inst (.*);
	// 100 ns period
	always #50 clk_sys = ~clk_sys;
	task automatic chk_val(input logic [19:0] g, input logic [19:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %0t value %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic [8:0] g, input logic [8:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %0t flags %h want %h", $time, g, e);
		end
	endtask
	task automatic compare;
		chk_val(20'(result), 20'(e_res));
		chk_val(program_counter, 20'(e_pc));
		chk_bit(status, 9'(e_st));
		chk_bit(9'(result_valid), 9'(e_rv));
		chk_bit(9'(branch_taken), 9'(e_bt));
	endtask
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// picks inputs, biased to edge operands and extreme offsets, then steps the model
	task automatic drive;
		x = xorshift(x);
		exec = x[0];
		op = iibu_pkg::iibu_op_t'(x[4:1] % 10);
		byte_mode = x[5];
		operand = x[6] ? edge_val[x[9:7]] : x[31:16];
		jump_offset = x[10] ? {x[11], {9{!x[11]}}} : x[25:16];
		load_status = !exec && x[12];
		load_pc = x[13] && x[14];
		status_in = x[24:16];
		pc_in = {x[31:16], x[3:0]};
		e_rv = 0;
		e_bt = 0;
		s = e_st;
		p = e_pc;
		if (load_status) e_st = status_in;
		if (load_pc) e_pc = pc_in;
		if (exec && op >= iibu_pkg::IIBU_OP_INC && op <= iibu_pkg::IIBU_OP_NOT)
		begin
			w = byte_mode ? 8 : 16;
			a = operand & ((1 << w) - 1);
			r = op == iibu_pkg::IIBU_OP_NOT ? a ^ ((1 << w) - 1) : a + int'(op);
			c = r >> w;
			r = r & ((1 << w) - 1);
			if (op == iibu_pkg::IIBU_OP_NOT) c = r != 0;
			v = op == iibu_pkg::IIBU_OP_NOT ? a >> (w - 1) : (r & ~a) >> (w - 1);
			e_st = e_st & 9'h0F8 | v << 8 | (r >> (w - 1) & 1) << 2 | (r == 0) << 1 | c;
			e_res = r;
			e_rv = 1;
		end
		if (exec && op == iibu_pkg::IIBU_OP_CLRV) e_st = e_st & 9'h0FF;
		if (exec && op >= iibu_pkg::IIBU_OP_BR_C && op <= iibu_pkg::IIBU_OP_BR_ANY)
		begin
			case (op)
				iibu_pkg::IIBU_OP_BR_C: e_bt = s & 1;
				iibu_pkg::IIBU_OP_BR_Z: e_bt = s >> 1 & 1;
				iibu_pkg::IIBU_OP_BR_GE: e_bt = !((s >> 2 ^ s >> 8) & 1);
				iibu_pkg::IIBU_OP_BR_LT: e_bt = (s >> 2 ^ s >> 8) & 1;
				default: e_bt = 1;
			endcase
			if (e_bt) e_pc = (p + 2 * ((jump_offset ^ 512) - 512)) & 20'hFFFFF;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, well above the 3012 cycles the run needs
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			miscompares++;
			complete_run;
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1 rst = 0;
		compare;
		$display("test reset done");
		repeat (3000)
		begin
			drive;
			@(posedge clk_sys);
			#1 compare;
		end
		$display("test random done");
		complete_run;
	end
endmodule // tb_iibu_unit
`default_nettype wire
